// File: design/adc_cfg_pkg.sv
package adc_cfg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int COEF_W = 24;

  localparam logic [ADDR_W-1:0] OFF_BURNOUT = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_BIAS = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_MUX = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_GAIN_RATE = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_OFC_LOW = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_OFC_MID = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_OFC_HIGH = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_FSC_LOW = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_FSC_MID = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_FSC_HIGH = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_REV_MODE = 4'ha;

  // fixed low pattern of the burnout register
  localparam logic [5:0] BURNOUT_FIXED = 6'h01;
  localparam int BURNOUT_POS = 6;
  localparam int GAIN_POS = 4;
  localparam int OSC_POS = 7;
  localparam int REV_POS = 4;
  localparam int MODE_POS = 3;

  localparam logic [1:0] BURNOUT_OFF = 2'h0;
  localparam logic [1:0] BURNOUT_0U5 = 2'h1;
  localparam logic [1:0] BURNOUT_2U = 2'h2;
  localparam logic [1:0] BURNOUT_10U = 2'h3;

  typedef enum logic [2:0] {
    MON_NORMAL = 3'b000,
    MON_OFFSET = 3'b001,
    MON_REFERENCE = 3'b010,
    MON_TEMP = 3'b011
  } monitor_t;

  localparam logic [2:0] GAIN_ONE = 3'h0;
  localparam logic [3:0] RATE_MAX = 4'h9;

  typedef enum logic [1:0] {
    RDY_IDLE = 2'b00,
    RDY_LOW = 2'b01,
    RDY_PULSE = 2'b10
  } ready_t;

  typedef struct packed {
    logic [1:0] burnout;
    logic [1:0] bias;
    logic [2:0] monitor;
    logic [2:0] gain;
    logic [3:0] rate;
    logic [COEF_W-1:0] ofc;
    logic [COEF_W-1:0] fsc;
    logic mode;
    ready_t rdy;
    logic [DATA_W-1:0] rdata;
  } state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] burnout_current_select;
    logic [1:0] bias_applied;
    logic [2:0] system_monitor_select;
    logic [2:0] effective_gain;
    logic [3:0] output_rate_select;
    logic [COEF_W-1:0] offset_coefficient;
    logic [COEF_W-1:0] fullscale_coefficient;
  } analog_ctrl_t;
endpackage

// File: design/adc_config_register_bank.sv
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - burnout field sets off, 0.5, 2, 10 uA
// - each bias bit biases its own input
// - oscillator flag bit 7 is read-only status
// - monitor selection overrides input bias enables
// - monitor code routes normal, short, reference, diode
// - reference and diode monitors force gain one
// - gain code selects gain two to code
// - rate codes 1001 and above mean 2000 sps
// - offset coefficient across 04h-06h, resets zero
// - fullscale coefficient 07h-09h, trimmed reset value
// - gain change reloads trimmed fullscale coefficient
// - revision code bits 7:4 read-only
// - mode bit merges ready onto data pin
// - combined pin falls on ready, high after readout
module adc_config_register_bank
  import adc_cfg_pkg::*;
#(
  // trimmed fullscale values per gain code; arbitrary defaults
  parameter logic [8*COEF_W-1:0] FSC_TRIM = {8{24'h400000}},
  // revision code value is arbitrary
  parameter logic [3:0] REVISION = 4'h5
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic ext_osc_i,
  input wire logic conv_done_i,
  input wire logic shift_active_i,
  input wire logic shift_bit_i,
  input wire logic readout_done_i,
  input wire logic chip_select_n_i,
  output analog_ctrl_t analog_ctrl_o,
  output logic data_out_ready_pin_o,
  output logic data_out_ready_pin_oe_n_o,
  output logic conversion_ready_pin_n_o
);

  function automatic logic [COEF_W-1:0] trim_for(input logic [2:0] g);
    trim_for = FSC_TRIM[g*COEF_W +: COEF_W];
  endfunction

  localparam state_t ST_RST = '{
    burnout: BURNOUT_OFF,
    bias: 2'h0,
    monitor: MON_NORMAL,
    gain: GAIN_ONE,
    rate: 4'h0,
    ofc: 24'h000000,
    fsc: FSC_TRIM[COEF_W-1:0],
    mode: 1'b0,
    rdy: RDY_IDLE,
    rdata: 8'h00
  };

  reg_req_t req;
  state_t st_q;
  state_t st_d;
  logic ready_level;
  logic mon_override;

  assign req = '{wr: reg_wr_i, rd: reg_rd_i, addr: reg_addr_i,
                 wdata: reg_wdata_i};

  always_comb begin
    st_d = st_q;
    if (req.wr) begin
      // reserved bits are not stored; they read as their fixed pattern
      case (req.addr)
        OFF_BURNOUT: st_d.burnout = req.wdata[BURNOUT_POS +: 2];
        OFF_BIAS: st_d.bias = req.wdata[1:0];
        OFF_MUX: st_d.monitor = req.wdata[2:0];
        OFF_GAIN_RATE: begin
          st_d.gain = req.wdata[GAIN_POS +: 3];
          st_d.rate = req.wdata[3:0];
          if (req.wdata[GAIN_POS +: 3] != st_q.gain) begin
            st_d.fsc = trim_for(req.wdata[GAIN_POS +: 3]);
          end
        end
        OFF_OFC_LOW: st_d.ofc[7:0] = req.wdata;
        OFF_OFC_MID: st_d.ofc[15:8] = req.wdata;
        OFF_OFC_HIGH: st_d.ofc[23:16] = req.wdata;
        OFF_FSC_LOW: st_d.fsc[7:0] = req.wdata;
        OFF_FSC_MID: st_d.fsc[15:8] = req.wdata;
        OFF_FSC_HIGH: st_d.fsc[23:16] = req.wdata;
        OFF_REV_MODE: st_d.mode = req.wdata[MODE_POS];
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        OFF_BURNOUT: st_d.rdata = {st_q.burnout, BURNOUT_FIXED};
        OFF_BIAS: st_d.rdata = {6'h00, st_q.bias};
        OFF_MUX: st_d.rdata = {ext_osc_i, 4'h0, st_q.monitor};
        OFF_GAIN_RATE: st_d.rdata = {1'b0, st_q.gain, st_q.rate};
        OFF_OFC_LOW: st_d.rdata = st_q.ofc[7:0];
        OFF_OFC_MID: st_d.rdata = st_q.ofc[15:8];
        OFF_OFC_HIGH: st_d.rdata = st_q.ofc[23:16];
        OFF_FSC_LOW: st_d.rdata = st_q.fsc[7:0];
        OFF_FSC_MID: st_d.rdata = st_q.fsc[15:8];
        OFF_FSC_HIGH: st_d.rdata = st_q.fsc[23:16];
        OFF_REV_MODE: st_d.rdata = {REVISION, st_q.mode, 3'h0};
        default: st_d.rdata = 8'h00;
      endcase
    end
    // ready indication; a new result beats a finishing readout
    case (st_q.rdy)
      RDY_IDLE: begin
        if (conv_done_i) begin
          st_d.rdy = RDY_LOW;
        end
      end
      RDY_LOW: begin
        if (conv_done_i) begin
          st_d.rdy = RDY_PULSE;
        end else if (readout_done_i) begin
          st_d.rdy = RDY_IDLE;
        end
      end
      RDY_PULSE: st_d.rdy = RDY_LOW;
      default: st_d.rdy = RDY_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign ready_level = (st_q.rdy != RDY_LOW);
  assign mon_override = (st_q.monitor != MON_NORMAL);
  assign reg_rdata_o = st_q.rdata;
  assign conversion_ready_pin_n_o = ready_level;

  always_comb begin
    analog_ctrl_o.burnout_current_select = st_q.burnout;
    // monitor wins so a bias never disturbs a calibration reading
    analog_ctrl_o.bias_applied = mon_override ? 2'h0 : st_q.bias;
    analog_ctrl_o.system_monitor_select = st_q.monitor;
    analog_ctrl_o.effective_gain = st_q.gain;
    if (st_q.monitor == MON_REFERENCE || st_q.monitor == MON_TEMP) begin
      analog_ctrl_o.effective_gain = GAIN_ONE;
    end
    analog_ctrl_o.output_rate_select = (st_q.rate > RATE_MAX) ?
                                       RATE_MAX : st_q.rate;
    analog_ctrl_o.offset_coefficient = st_q.ofc;
    analog_ctrl_o.fullscale_coefficient = st_q.fsc;
  end

  // pin floats while deselected; shifted data always has priority
  assign data_out_ready_pin_oe_n_o = chip_select_n_i;
  assign data_out_ready_pin_o = (st_q.mode && !shift_active_i) ?
                                ready_level : shift_bit_i;

  chk_rd_osc_flag: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == OFF_MUX |=> reg_rdata_o[OSC_POS] ==
    $past(ext_osc_i))
    else $error("oscillator flag read wrong");

  chk_bias_override: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    st_q.monitor != MON_NORMAL |-> analog_ctrl_o.bias_applied == 2'h0)
    else $error("bias applied during monitor");

  chk_gain_forced: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (st_q.monitor == MON_REFERENCE || st_q.monitor == MON_TEMP) |->
    analog_ctrl_o.effective_gain == GAIN_ONE)
    else $error("gain not forced to one");

  chk_gain_normal: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    (st_q.monitor == MON_NORMAL || st_q.monitor == MON_OFFSET) |->
    analog_ctrl_o.effective_gain == st_q.gain)
    else $error("programmed gain not used");

  chk_rate_sat: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    analog_ctrl_o.output_rate_select <= RATE_MAX)
    else $error("rate code above maximum");

  chk_fsc_reload: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == OFF_GAIN_RATE &&
    reg_wdata_i[GAIN_POS +: 3] != st_q.gain |=>
    st_q.fsc == trim_for($past(reg_wdata_i[GAIN_POS +: 3])))
    else $error("fullscale not reloaded");

  chk_rev_const: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    reg_rd_i && reg_addr_i == OFF_REV_MODE |=>
    reg_rdata_o[REV_POS +: 4] == REVISION)
    else $error("revision code wrong");

  chk_ofc_readback: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    reg_wr_i && reg_addr_i == OFF_OFC_HIGH ##1 !reg_wr_i ##1
    reg_rd_i && reg_addr_i == OFF_OFC_HIGH && !reg_wr_i |=>
    reg_rdata_o == $past(reg_wdata_i, 3))
    else $error("offset byte readback wrong");

  sequence ready_while_low;
    st_q.rdy == RDY_LOW && conv_done_i;
  endsequence

  chk_ready_pulse: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    ready_while_low |=> conversion_ready_pin_n_o ##1
    !conversion_ready_pin_n_o)
    else $error("ready pulse missing");

  chk_ready_release: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    st_q.rdy == RDY_LOW && readout_done_i && !conv_done_i |=>
    conversion_ready_pin_n_o)
    else $error("ready not released");

endmodule
`default_nettype wire

// File: tb/adc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_host_model
  import adc_cfg_pkg::*;
(
  input wire logic core_clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end
  // a careful host writes reserved bits only as their fixed pattern
  function automatic logic [7:0] fix(input logic [3:0] a,
    input logic [7:0] d);
    case (a)
      OFF_BURNOUT: return {d[7:6], BURNOUT_FIXED};
      OFF_BIAS: return {6'h00, d[1:0]};
      OFF_MUX: return {5'h00, d[2:0]};
      OFF_GAIN_RATE: return {1'b0, d[6:0]};
      OFF_REV_MODE: return {d[7:3], 3'h0};
      default: return d;
    endcase
  endfunction
  // one strobe cycle; data toggled on reads so nothing stale shows
  task automatic access(input logic w, input logic [3:0] a,
    input logic [7:0] d);
    @(posedge core_clk_i) #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = w ? fix(a, d) : ~wdata_o;
    @(posedge core_clk_i) #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb/test_adc_config_register_bank.sv
`timescale 1ns/100ps
`default_nettype none
module test_adc_config_register_bank
  import adc_cfg_pkg::*;
;
  // arbitrary revision code
  localparam logic [3:0] REV = 4'h9;
  function automatic logic [23:0] trim(input int g);
    return 24'h400000 + 24'h010203 * 24'(g);
  endfunction
  function automatic logic [191:0] mk_trim();
    logic [191:0] t;
    for (int g = 0; g < 8; g++) begin
      t[g*24 +: 24] = trim(g);
    end
    return t;
  endfunction
  localparam logic [191:0] TRIM = mk_trim();
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic osc = 1'b0, conv = 1'b0, shact = 1'b0, sbit = 1'b0;
  logic rdone = 1'b0, cs_n = 1'b0, rd_seen = 1'b0, taken, wr, rd;
  logic dpin, dpin_oe_n, rdy_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, r;
  logic [23:0] o;
  logic [31:0] seed = 32'h27;
  logic [7:0] q[$];
  logic [7:0] rst_val [11] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h40, {REV, 4'h0}};
  analog_ctrl_t actl;
  int n_fail = 0, total_checks = 0;
  always #5 core_clk_i = ~core_clk_i;
  adc_host_model host (.core_clk_i(core_clk_i), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));
  adc_config_register_bank #(.FSC_TRIM(TRIM), .REVISION(REV)) uut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .ext_osc_i(osc), .conv_done_i(conv),
    .shift_active_i(shact), .shift_bit_i(sbit), .readout_done_i(rdone),
    .chip_select_n_i(cs_n), .analog_ctrl_o(actl),
    .data_out_ready_pin_o(dpin), .data_out_ready_pin_oe_n_o(dpin_oe_n),
    .conversion_ready_pin_n_o(rdy_n));
  task automatic cmp(input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    r = seed[7:0];
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    host.access(1'b1, a, d);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    q.push_back(e);
    host.access(1'b0, a, 8'h00);
  endtask
  task automatic pulse(ref logic s);
    @(posedge core_clk_i) #1;
    s = 1'b1;
    @(posedge core_clk_i) #1;
    s = 1'b0;
  endtask
  task automatic pin(input logic e, input logic g);
    cmp({23'h0, e}, {23'h0, g});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // read data lands one edge after the strobe is taken
  always @(posedge core_clk_i) begin
    taken = rd;
    #2;
    if (rd_seen) begin
      cmp({16'h0, q.pop_front()}, {16'h0, rdata});
    end
    rd_seen = taken;
  end
  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge core_clk_i) #1;
    sys_rst_i = 1'b0;
    wr_reg(4'hb, 8'hff);
    for (int i = 0; i < 11; i++) begin
      rd_reg(4'(i), rst_val[i]);
    end
    rd_reg(4'hb, 8'h00);
    for (int b = 0; b < 4; b++) begin
      wr_reg(OFF_BURNOUT, {2'(b), 6'h00});
      cmp(24'(b), 24'(actl.burnout_current_select));
      rd_reg(OFF_BURNOUT, {2'(b), 6'h01});
    end
    for (int g = 1; g < 8; g++) begin
      rnd();
      wr_reg(OFF_FSC_HIGH, r);
      if (g == 7) r[3:0] = 4'hf;
      wr_reg(OFF_GAIN_RATE, {1'b0, 3'(g), r[3:0]});
      cmp(24'(g), 24'(actl.effective_gain));
      cmp(24'(r[3:0] > RATE_MAX ? RATE_MAX : r[3:0]),
        24'(actl.output_rate_select));
      cmp(trim(g), actl.fullscale_coefficient);
    end
    o = trim(7);
    rd_reg(OFF_FSC_MID, o[15:8]);
    for (int i = 0; i < 3; i++) begin
      rnd();
      o[i*8 +: 8] = r;
      wr_reg(4'(4 + i), r);
    end
    cmp(o, actl.offset_coefficient);
    rd_reg(OFF_OFC_HIGH, o[23:16]);
    for (int v = 0; v < 4; v++) begin
      wr_reg(OFF_BIAS, 8'(v));
      cmp(24'(v), 24'(actl.bias_applied));
    end
    osc = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr_reg(OFF_MUX, 8'(m));
      cmp(24'(m), 24'(actl.system_monitor_select));
      cmp(m == 0 ? 24'h3 : 24'h0, 24'(actl.bias_applied));
      cmp(m > 1 ? 24'h0 : 24'h7, 24'(actl.effective_gain));
      rd_reg(OFF_MUX, {5'h10, 3'(m)});
    end
    wr_reg(OFF_MUX, 8'h01);
    cmp(24'h7, 24'(actl.effective_gain));
    wr_reg(OFF_REV_MODE, 8'hff);
    rd_reg(OFF_REV_MODE, {REV, 4'h8});
    pulse(conv);
    pin(1'b0, rdy_n);
    pin(1'b0, dpin);
    pulse(conv);
    pin(1'b1, dpin);
    @(posedge core_clk_i) #1;
    pin(1'b0, dpin);
    shact = 1'b1;
    sbit = 1'b1;
    #1 pin(1'b1, dpin);
    pulse(rdone);
    pin(1'b1, rdy_n);
    wr_reg(OFF_REV_MODE, 8'h00);
    shact = 1'b0;
    pulse(conv);
    pin(1'b0, rdy_n);
    pin(1'b1, dpin);
    cs_n = 1'b1;
    #1 pin(1'b1, dpin_oe_n);
    repeat (3) @(posedge core_clk_i);
    conclude();
  end
endmodule
`default_nettype wire
